// ===== verilog/mqw_pkg.sv
/*
 Constants and carrier types for the multi-queue write-port select block.
 Assumes one free-running write clock and an asynchronous active-high reset.
*/
// What this block does
// - Flag bus and selected-queue flags stay high-impedance until test port reset
// - Strobe high on edge captures queue address
// - Enabled edge stores data in selected queue
// - Queue selection works regardless of write enable
// - New queue writable two edges after selection
// - Selecting and next edge write old queue
// - Address: low 2 bits queue, high 3 device
// - Addressing accepted only on matching device ID
// - Flag strobe selects device for almost-full bus
// - Flag bus cycling needs no write enable
// - Polled mode steps flag bus, makes sync
// - Flags update synchronous to write clock
// - Expansion flag out driven, in sampled, on clock
// - Configuration done goes low after programming
package mqw_pkg;
   localparam int ADDR_W       = 5;
   localparam int QUEUE_W      = 2;
   localparam int DEV_W        = 3;
   localparam int NUM_QUEUES   = 4;
   localparam int DATA_W       = 36;
   localparam int SEL_DELAY    = 2;
   localparam int PROG_CYCLES  = 16;
   localparam logic [QUEUE_W-1:0] QUEUE_RESET = 2'h0;

   typedef struct packed {
      logic                 strobe;
      logic [ADDR_W-1:0]    addr;
   } mqw_sel_type;

   typedef struct packed {
      logic                 valid;
      logic [QUEUE_W-1:0]   queue;
      logic [DATA_W-1:0]    data;
   } mqw_wr_type;

   typedef enum logic [1:0] {
      MQW_PROG  = 2'b00,
      MQW_READY = 2'b01
   } mqw_state_type;
endpackage

// ===== verilog/mqw_select_pipe.sv
/*
 Queue selection pipeline: holds the active write target and its pending successor.
 Assumes selection strobes are taken as synchronous to the clock.
*/
`timescale 1ns/1ps
module mqw_select_pipe #(
   parameter int DELAY = mqw_pkg::SEL_DELAY
) (
   input  wire logic                        CLK_I,     // Write clock
   input  wire logic                        RESET_I,   // Async reset
   input  wire logic                        load_i,    // Accepted selection
   input  wire logic                        match_i,   // Device ID matched
   input  wire logic [mqw_pkg::QUEUE_W-1:0] queue_i,   // Requested queue
   output logic      [mqw_pkg::QUEUE_W-1:0] active_o,  // Queue taking writes
   output logic                             enabled_o  // This device addressed
);
   logic [DELAY-2:0]            pend_reg;
   logic [mqw_pkg::QUEUE_W-1:0] q_pend_reg;
   logic                        m_pend_reg;
   logic [mqw_pkg::QUEUE_W-1:0] active_reg;
   logic                        enabled_reg;
   wire                         apply = pend_reg[DELAY-2];

   // Switch lands one edge after the strobe, so only the selecting edge and the next hit the old queue.
   // A fresh strobe restarts the count: the latest queue wins and no stale target is applied.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pend_reg    <= '0;
         q_pend_reg  <= mqw_pkg::QUEUE_RESET;
         m_pend_reg  <= 1'b0;
         active_reg  <= mqw_pkg::QUEUE_RESET;
         enabled_reg <= 1'b0;
      end else begin
         if (load_i)
            pend_reg <= (DELAY-1)'(1);
         else
            pend_reg <= (DELAY-1)'({pend_reg, 1'b0});
         if (load_i) begin
            q_pend_reg <= queue_i;
            m_pend_reg <= match_i;
         end
         if (apply && !load_i) begin
            active_reg  <= q_pend_reg;
            enabled_reg <= m_pend_reg;
         end
      end
   end

   assign active_o  = active_reg;
   assign enabled_o = enabled_reg;

   chk_switch_delay: assert property (@(posedge CLK_I) disable iff (RESET_I)
      load_i ##1 !load_i |=> active_o == $past(q_pend_reg))
      else $error("queue switch not two edges after select");
   chk_old_queue_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
      load_i |=> $stable(active_o))
      else $error("queue switched too early");
endmodule

// ===== verilog/mqw_flag_bus.sv
/*
 Almost-full flag bus driver: strobed device selection or polled stepping.
 Assumes per-queue almost-full levels arrive on the write clock.
*/
`timescale 1ns/1ps
module mqw_flag_bus #(
   parameter int NQ = mqw_pkg::NUM_QUEUES
) (
   input  wire logic                       CLK_I,      // Write clock
   input  wire logic                       RESET_I,    // Async reset
   input  wire logic                       polled_i,   // Polled mode
   input  wire logic                       strobe_i,   // Flag device strobe
   input  wire logic                       id_hit_i,   // High address matches ID
   input  wire logic                       ready_i,    // Configured
   input  wire logic                       expand_in_i,// Token from prior device
   input  wire logic [NQ-1:0]              afull_i,    // Per-queue almost full
   output logic      [NQ-1:0]              bus_o,      // Flag bus value
   output logic                            bus_oe_o,   // Flag bus driven
   output logic                            sync_o,     // Polled sync
   output logic                            expand_out_o// Token to next device
);
   logic [NQ-1:0] bus_reg;
   logic          own_reg;
   logic          sync_reg;
   logic          xo_reg;
   logic          xi_reg;

   // Device owns the bus after a matching strobe, or while holding the poll token
   wire own_next = polled_i ? (xi_reg | (own_reg & ~xo_reg)) :
                   (strobe_i ? id_hit_i : own_reg);

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         bus_reg  <= '0;
         own_reg  <= 1'b0;
         sync_reg <= 1'b0;
         xo_reg   <= 1'b0;
         xi_reg   <= 1'b0;
      end else begin
         xi_reg   <= expand_in_i;
         own_reg  <= ready_i & own_next;
         bus_reg  <= afull_i;
         sync_reg <= ready_i & polled_i & xi_reg;
         xo_reg   <= ready_i & polled_i & own_reg & ~xo_reg;
      end
   end

   assign bus_o        = bus_reg;
   assign bus_oe_o     = own_reg;
   assign sync_o       = sync_reg;
   assign expand_out_o = xo_reg;

   chk_strobe_select: assert property (@(posedge CLK_I) disable iff (RESET_I)
      ready_i && !polled_i && strobe_i |=> bus_oe_o == $past(id_hit_i))
      else $error("strobed device selection wrong");
endmodule

// ===== verilog/mqw_write_port.sv
/*
 Write-port control of a four-queue FIFO device with cascade addressing.
 Assumes a free-running write clock and a controller that keeps the strobe rules.
 Queue storage itself sits downstream on the write request output.
*/
`timescale 1ns/1ps
module mqw_write_port #(
   parameter int                  DATA_W = mqw_pkg::DATA_W,
   parameter logic [2:0]          DEV_ID = 3'h0,   // Expansion ID of this device
   parameter int                  PROG_N = mqw_pkg::PROG_CYCLES
) (
   input  wire logic              CLK_I,           // Write clock
   input  wire logic              RESET_I,         // Master reset
   input  wire logic              TEST_RESET_DONE_I, // Test port has been reset
   input  wire logic              CONFIG_IN_N_I,   // Upstream config done, low
   input  wire logic              WRITE_EN_N_I,    // Write enable, low
   input  wire logic [35:0]       DATA_I,          // Input data bus
   input  wire logic              QUEUE_SELECT_STROBE_I, // Queue select strobe
   input  wire logic              FLAG_DEVICE_STROBE_I,  // Flag device strobe
   input  wire logic [4:0]        WRITE_QUEUE_ADDRESS_I, // Queue/device address
   input  wire logic              POLLED_MODE_I,   // Polled flag bus mode
   input  wire logic [3:0]        QUEUE_ALMOST_FULL_I,   // Per-queue almost full
   input  wire logic [3:0]        QUEUE_FULL_I,    // Per-queue full
   input  wire logic              FLAG_EXPAND_IN_I,// Poll token in
   output logic                   CONFIG_DONE_OUT_N_O,   // Config done, low
   output logic                   WR_VALID_O,      // Store strobe
   output logic [1:0]             WR_QUEUE_O,      // Store target
   output logic [35:0]            WR_DATA_O,       // Store data
   output logic [3:0]             ALMOST_FULL_STATUS_BUS_O, // Flag bus
   output logic                   ALMOST_FULL_STATUS_BUS_OE_O, // Flag bus enable
   output logic                   ALMOST_FULL_FLAG_SEL_O, // Selected-queue almost full
   output logic                   ALMOST_FULL_FLAG_SEL_OE_O, // Its enable
   output logic                   FULL_FLAG_O,     // Selected-queue full
   output logic                   FULL_FLAG_OE_O,  // Its enable
   output logic                   FLAG_BUS_SYNC_O, // Polled sync
   output logic                   FLAG_EXPAND_OUT_O // Poll token out
);
   mqw_pkg::mqw_state_type  state_reg;
   mqw_pkg::mqw_state_type  state_next;
   logic [7:0]              prog_cnt_reg;
   logic                    cfg_done_reg;
   mqw_pkg::mqw_wr_type     wr_reg;
   logic                    paf_reg;
   logic                    ff_reg;
   logic                    outputs_live_reg;
   mqw_pkg::mqw_sel_type    sel;
   logic [1:0]              active_q;
   logic                    port_enabled;
   logic [3:0]              bus_val;
   logic                    bus_oe;
   logic                    sync_val;
   logic                    xo_val;

   function automatic logic id_match(input logic [4:0] a);
      id_match = a[4:2] == DEV_ID;
   endfunction

   assign sel = {QUEUE_SELECT_STROBE_I, WRITE_QUEUE_ADDRESS_I};

   wire ready     = (state_reg == mqw_pkg::MQW_READY);
   // Selection ignores write enable entirely
   wire sel_take  = ready & sel.strobe;
   wire sel_hit   = id_match(sel.addr);
   wire flag_hit  = id_match(WRITE_QUEUE_ADDRESS_I);
   wire store     = ready & port_enabled & ~WRITE_EN_N_I;
   wire prog_done = (prog_cnt_reg == 8'(PROG_N - 1));

   // Programming phase: count out a fixed setup time, then wait for upstream done
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mqw_pkg::MQW_PROG: begin
            if (prog_done && !CONFIG_IN_N_I)
               state_next = mqw_pkg::MQW_READY;
         end
         mqw_pkg::MQW_READY: state_next = mqw_pkg::MQW_READY;
         default:            state_next = mqw_pkg::MQW_PROG;
      endcase
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_reg    <= mqw_pkg::MQW_PROG;
         prog_cnt_reg <= 8'h00;
         cfg_done_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         if (!prog_done)
            prog_cnt_reg <= prog_cnt_reg + 8'h01;
         cfg_done_reg <= (state_next == mqw_pkg::MQW_READY);
      end
   end

   // Config done follows upstream once this device is programmed
   assign CONFIG_DONE_OUT_N_O = ~cfg_done_reg | CONFIG_IN_N_I;

   mqw_select_pipe #(
      .DELAY (mqw_pkg::SEL_DELAY)
   ) u_sel (
      .CLK_I     (CLK_I),
      .RESET_I   (RESET_I),
      .load_i    (sel_take),
      .match_i   (sel_hit),
      .queue_i   (sel.addr[1:0]),
      .active_o  (active_q),
      .enabled_o (port_enabled)
   );

   mqw_flag_bus #(
      .NQ (mqw_pkg::NUM_QUEUES)
   ) u_flags (
      .CLK_I        (CLK_I),
      .RESET_I      (RESET_I),
      .polled_i     (POLLED_MODE_I),
      .strobe_i     (FLAG_DEVICE_STROBE_I),
      .id_hit_i     (flag_hit),
      .ready_i      (ready),
      .expand_in_i  (FLAG_EXPAND_IN_I),
      .afull_i      (QUEUE_ALMOST_FULL_I),
      .bus_o        (bus_val),
      .bus_oe_o     (bus_oe),
      .sync_o       (sync_val),
      .expand_out_o (xo_val)
   );

   // Registered store request and selected-queue flags
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wr_reg           <= '0;
         paf_reg          <= 1'b0;
         ff_reg           <= 1'b0;
         outputs_live_reg <= 1'b0;
      end else begin
         wr_reg.valid     <= store;
         wr_reg.queue     <= active_q;
         wr_reg.data      <= DATA_I;
         paf_reg          <= QUEUE_ALMOST_FULL_I[active_q];
         ff_reg           <= QUEUE_FULL_I[active_q];
         outputs_live_reg <= TEST_RESET_DONE_I;
      end
   end

   assign WR_VALID_O  = wr_reg.valid;
   assign WR_QUEUE_O  = wr_reg.queue;
   assign WR_DATA_O   = wr_reg.data;

   // Flag bus and selected-queue flag pins float until the test port has seen its reset; sync and expansion out are always driven
   assign ALMOST_FULL_STATUS_BUS_O     = bus_val;
   assign ALMOST_FULL_STATUS_BUS_OE_O  = bus_oe & outputs_live_reg;
   assign ALMOST_FULL_FLAG_SEL_O       = paf_reg;
   assign ALMOST_FULL_FLAG_SEL_OE_O    = outputs_live_reg & port_enabled;
   assign FULL_FLAG_O                  = ff_reg;
   assign FULL_FLAG_OE_O               = outputs_live_reg & port_enabled;
   assign FLAG_BUS_SYNC_O              = sync_val;
   assign FLAG_EXPAND_OUT_O            = xo_val;

   chk_store_enable: assert property (@(posedge CLK_I) disable iff (RESET_I)
      ready && port_enabled && !WRITE_EN_N_I |=> WR_VALID_O && WR_DATA_O == $past(DATA_I))
      else $error("enabled write not stored");
   chk_no_store_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
      !port_enabled || WRITE_EN_N_I |=> !WR_VALID_O)
      else $error("store without enable or addressing");
   chk_sel_no_wen: assert property (@(posedge CLK_I) disable iff (RESET_I)
      sel_take && WRITE_EN_N_I ##1 !sel_take |=> active_q == $past(sel.addr[1:0], 2))
      else $error("selection needs write enable");
   chk_outputs_float: assert property (@(posedge CLK_I) disable iff (RESET_I)
      !$past(TEST_RESET_DONE_I) |-> !FULL_FLAG_OE_O && !ALMOST_FULL_STATUS_BUS_OE_O)
      else $error("output driven before test reset");
   chk_full_flag: assert property (@(posedge CLK_I) disable iff (RESET_I)
      1'b1 |=> FULL_FLAG_O == $past(QUEUE_FULL_I[active_q]))
      else $error("full flag not tracking queue");
   chk_config_done: assert property (@(posedge CLK_I) disable iff (RESET_I)
      !ready |-> CONFIG_DONE_OUT_N_O)
      else $error("config done before programming");
endmodule

// ===== testbench/mqw_ctrl_model.sv
/*
 Write-side controller model: drives the write port for one clock cycle per call of cycle().
 Assumes a single caller process and a clock that never stops.
*/
`timescale 1ns/1ps
module mqw_ctrl_model (
   input  wire logic            CLK_I,        // Write clock
   input  wire logic            RESET_I,      // Master reset
   input  wire logic            cfg_done_n_i, // Device configured, low
   input  wire logic            tap_hold_i,   // Hold the test port in reset
   output logic                 test_rst_o,   // Test port reset done
   output logic                 wen_n_o,      // Write enable, low
   output logic [35:0]          data_o,       // Write data
   output mqw_pkg::mqw_sel_type sel_o,        // Queue strobe and address
   output logic                 flag_device_strobe_o        // Flag device strobe
);
   int   tap_cnt;
   logic tap_ok;

   initial begin
      wen_n_o = 1'b1;
      data_o = 36'h0;
      sel_o = '0;
      flag_device_strobe_o = 1'b0;
   end

   // Test port follows master reset, then sees five clocks of mode-select high
   always @(negedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tap_cnt = 0;
         tap_ok = 1'b0;
      end else if (tap_cnt < 5) begin
         tap_cnt++;
      end else begin
         tap_ok = 1'b1;
      end
   end
   assign test_rst_o = tap_ok && !tap_hold_i;

   // Released buses toggle so that stale values never pass for a request
   task automatic cycle(input bit en, input logic [35:0] d, input bit qs, input bit fs, input logic [4:0] a);
      @(negedge CLK_I);
      wen_n_o <= !en;
      data_o <= en ? d : ~data_o;
      sel_o.strobe <= qs && !cfg_done_n_i;
      flag_device_strobe_o <= fs && !qs;
      sel_o.addr <= (qs || fs) ? a : ~sel_o.addr;
   endtask
endmodule

// ===== testbench/tb_top.sv
/*
 Self-checking bench for the write-port select block with a cycle reference model.
 Assumes the controller model drives all strobe and write inputs on falling edges.
*/
`timescale 1ns/1ps
module tb_top;
   localparam logic [2:0] DEV  = 3'h5;
   localparam int         PROG = 4;
   logic clk, rst, tap_hold, cfg_in_n, polled, xin, cfg_done_n, test_rst, wen_n, flag_device_strobe;
   logic wr_valid, afs_oe, af_sel, af_sel_oe, ff, ff_oe, flag_bus_sync, xout, seen_x, seen_oe, seen_s;
   logic [35:0] data, wr_data;
   logic [3:0]  af, full, afs_bus;
   logic [1:0]  wr_queue, act, pend;
   logic [63:0] rv;
   mqw_pkg::mqw_sel_type sel;
   mqw_pkg::mqw_wr_type  exp_q[$];
   mqw_pkg::mqw_wr_type  exp_w;
   int     error_cnt, num_checks, cnt, i, k;
   bit     en, pend_en;
   integer seed = 32'h9157;

   mqw_write_port #(.DEV_ID(DEV), .PROG_N(PROG)) u_dut (
      .CLK_I(clk), .RESET_I(rst), .TEST_RESET_DONE_I(test_rst), .CONFIG_IN_N_I(cfg_in_n),
      .WRITE_EN_N_I(wen_n), .DATA_I(data), .QUEUE_SELECT_STROBE_I(sel.strobe),
      .FLAG_DEVICE_STROBE_I(flag_device_strobe), .WRITE_QUEUE_ADDRESS_I(sel.addr), .POLLED_MODE_I(polled),
      .QUEUE_ALMOST_FULL_I(af), .QUEUE_FULL_I(full), .FLAG_EXPAND_IN_I(xin),
      .CONFIG_DONE_OUT_N_O(cfg_done_n), .WR_VALID_O(wr_valid), .WR_QUEUE_O(wr_queue),
      .WR_DATA_O(wr_data), .ALMOST_FULL_STATUS_BUS_O(afs_bus), .ALMOST_FULL_STATUS_BUS_OE_O(afs_oe),
      .ALMOST_FULL_FLAG_SEL_O(af_sel), .ALMOST_FULL_FLAG_SEL_OE_O(af_sel_oe), .FULL_FLAG_O(ff),
      .FULL_FLAG_OE_O(ff_oe), .FLAG_BUS_SYNC_O(flag_bus_sync), .FLAG_EXPAND_OUT_O(xout));

   mqw_ctrl_model u_ctrl (
      .CLK_I(clk), .RESET_I(rst), .cfg_done_n_i(cfg_done_n), .tap_hold_i(tap_hold),
      .test_rst_o(test_rst), .wen_n_o(wen_n), .data_o(data), .sel_o(sel), .flag_device_strobe_o(flag_device_strobe));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) u_ctrl.cycle(1'b0, 36'h0, 1'b0, 1'b0, 5'h0);
   endtask

   // Reference: one store per enabled edge, new queue only from the second edge after selection
   // Looks just after the edge, so the outputs seen are the ones that edge launched
   always @(posedge clk) begin
      #1;
      if (rst) begin
         exp_q.delete();
         act = 2'h0;
         cnt = 0;
         en = 1'b0;
      end else begin
         if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
               act = pend;
               en = pend_en;
            end
         end
         if (wen_n === 1'b0 && en)
            exp_q.push_back({1'b1, act, data});
         if (sel.strobe === 1'b1) begin
            pend = sel.addr[1:0];
            pend_en = (sel.addr[4:2] == DEV);
            cnt = 2;
         end
         if (exp_q.size() > 0) begin
            exp_w = exp_q.pop_front();
            check({wr_valid, wr_queue, wr_data}, exp_w);
         end else begin
            check(wr_valid, 1'b0);
         end
      end
   end

   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      tap_hold = 1'b0;
      cfg_in_n = 1'b0;
      polled = 1'b0;
      xin = 1'b0;
      af = 4'h0;
      full = 4'h0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      for (i = 1; i <= PROG; i++) begin
         @(posedge clk);
         #1;
         check(cfg_done_n, i < PROG);
      end
      @(negedge clk);
      cfg_in_n = 1'b1;
      #1;
      check(cfg_done_n, 1'b1);
      cfg_in_n = 1'b0;
      #1;
      check(cfg_done_n, 1'b0);
      idle(4);
      for (k = 0; k < 3; k++) begin
         rv = {$random(seed), $random(seed)};
         u_ctrl.cycle(1'b1, rv[35:0], 1'b0, 1'b0, 5'h0);
      end
      // Random writes mixed with back-to-back and write-disabled selections
      for (k = 0; k < 80; k++) begin
         rv = {$random(seed), $random(seed)};
         u_ctrl.cycle(rv[40], rv[35:0], rv[41] && rv[42], 1'b0, {DEV, rv[44:43]});
      end
      for (k = 0; k < 4; k++) begin
         rv = {$random(seed), $random(seed)};
         af = rv[3:0];
         full = rv[7:4];
         u_ctrl.cycle(1'b0, 36'h0, 1'b1, 1'b0, {DEV, k[1:0]});
         idle(4);
         @(posedge clk);
         #1;
         check({ff_oe, ff, af_sel_oe, af_sel}, {1'b1, full[k], 1'b1, af[k]});
      end
      for (k = 0; k < 2; k++) begin
         rv = {$random(seed), $random(seed)};
         af = rv[3:0];
         u_ctrl.cycle(1'b0, 36'h0, 1'b0, 1'b1, {DEV ^ k[2:0], rv[5:4]});
         idle(2);
         #1;
         check({afs_oe, afs_oe ? afs_bus : 4'h0}, {k == 0, k == 0 ? af : 4'h0});
      end
      u_ctrl.cycle(1'b0, 36'h0, 1'b0, 1'b1, {DEV, 2'h0});
      tap_hold = 1'b1;
      idle(2);
      #1;
      check({afs_oe, af_sel_oe, ff_oe}, 3'h0);
      tap_hold = 1'b0;
      u_ctrl.cycle(1'b0, 36'h0, 1'b1, 1'b0, {DEV ^ 3'h2, 2'h1});
      idle(2);
      for (k = 0; k < 3; k++)
         u_ctrl.cycle(1'b1, 36'hA5A5A5A5A, 1'b0, 1'b0, 5'h0);
      idle(1);
      #1;
      check(ff_oe, 1'b0);
      // Drop bus ownership first so that only the token can bring it back
      u_ctrl.cycle(1'b0, 36'h0, 1'b0, 1'b1, {DEV ^ 3'h1, 2'h0});
      idle(1);
      #1;
      check(afs_oe, 1'b0);
      polled = 1'b1;
      xin = 1'b1;
      idle(1);
      xin = 1'b0;
      seen_x = 1'b0;
      seen_oe = 1'b0;
      seen_s = 1'b0;
      for (k = 0; k < 5; k++) begin
         idle(1);
         #1;
         seen_x = seen_x | (xout === 1'b1);
         seen_oe = seen_oe | (afs_oe === 1'b1 && afs_bus === af);
         seen_s = seen_s | (flag_bus_sync === 1'b1);
      end
      check(seen_x, 1'b1);
      check(seen_s, 1'b1);
      check(seen_oe, 1'b1);
      idle(2);
      give_verdict();
   end
endmodule
